// File: rtl/wdg_pkg.sv
// Constants and types for the watchdog with option bits
package wdg_pkg;

	localparam int unsigned ADDR_W = 18;

	// Printed offsets are register indices; byte address is four times each
	localparam logic [15:0] IDX_WATCHDOG_CLEAR      = 16'hFFFF;
	localparam logic [15:0] IDX_OPTION_CONTROL_ONE  = 16'h001F;
	localparam logic [15:0] IDX_WATCHDOG_STATUS     = 16'h0020;

	localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_CLEAR     = {IDX_WATCHDOG_CLEAR, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_OPTION_CONTROL_ONE = {IDX_OPTION_CONTROL_ONE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_WATCHDOG_STATUS    = {IDX_WATCHDOG_STATUS, 2'b00};

	// Option register field positions
	localparam int unsigned OPT_WATCHDOG_RATE_SELECT = 7;
	localparam int unsigned OPT_LV_STOP_ENABLE       = 6;
	localparam int unsigned OPT_LV_RESET_DISABLE     = 5;
	localparam int unsigned OPT_LV_POWER_DISABLE     = 4;
	localparam int unsigned OPT_LV_TRIP_SELECT       = 3;
	localparam int unsigned OPT_SHORT_STOP_RECOVERY  = 2;
	localparam int unsigned OPT_STOP_ENABLE          = 1;
	localparam int unsigned OPT_WATCHDOG_DISABLE     = 0;
	localparam logic [7:0]  OPT_RESET_VALUE          = 8'h00;

	// Status register field positions
	localparam int unsigned STS_WATCHDOG_FLAG = 0;
	localparam int unsigned STS_IN_STOP       = 1;
	localparam int unsigned STS_OPT_WRITTEN   = 2;
	localparam int unsigned STS_COUNT_LSB     = 8;

	// Cycle counts at the oscillator clock
	localparam int unsigned PRE_W             = 12;
	localparam int unsigned CNT_W             = 6;
	localparam logic [11:0] PRE_LONG_EXPIRE   = 12'hFEF;
	localparam logic [6:0]  PRE_SHORT_EXPIRE  = 7'h6F;
	localparam logic [6:0]  PRE_SHORT_WRAP    = 7'h7F;
	localparam logic [11:0] PRE_LONG_WRAP     = 12'hFFF;
	localparam logic [5:0]  CNT_LAST          = 6'h3F;
	localparam logic [5:0]  RESET_PULSE_CYC   = 6'h20;
	localparam logic [12:0] RECOVER_SHORT_CYC = 13'h0020;
	localparam logic [12:0] RECOVER_LONG_CYC  = 13'h1000;
	localparam logic [12:0] POWER_UP_CYC      = 13'h1000;

	typedef enum logic [2:0] {
		WDG_RUN     = 3'b001,
		WDG_STOPPED = 3'b010,
		WDG_RECOVER = 3'b100
	} wdg_mode_e;

endpackage

// File: rtl/wdg_top.sv
// Watchdog with prescaler, write-once option register and APB slave
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module wdg_top #(
	parameter logic [7:0] RESET_VECTOR_LOW = 8'h00
) (
	input  wire logic                        pclk,                  // Oscillator clock
	input  wire logic                        presetn,               // Power-on reset, low
	input  wire logic                        psel,                  // APB select
	input  wire logic                        penable,               // APB enable
	input  wire logic                        pwrite,                // APB direction
	input  wire logic [wdg_pkg::ADDR_W-1:0]  paddr,                 // APB byte address
	input  wire logic [31:0]                 pwdata,                // APB write data
	output logic      [31:0]                 prdata,                // APB read data
	output logic                             pready,                // APB ready
	output logic                             pslverr,               // APB error
	input  wire logic                        internal_reset_req,    // Other internal reset
	input  wire logic                        stop_exec,             // Stop instruction pulse
	input  wire logic                        stop_wake,             // Stop exit request
	input  wire logic                        lv_reset_exit,         // Stop exit by LV reset
	input  wire logic                        monitor_mode,          // Monitor mode active
	input  wire logic                        test_voltage_pin,      // Test voltage on irq pin
	input  wire logic                        break_active,          // Break interrupt active
	input  wire logic                        break_watchdog_disable, // Break aux disable bit
	input  wire logic                        reset_pin_enable,      // Reset pin function on
	output logic                             watchdog_reset,        // Internal reset request
	output logic                             reset_pin_o,           // Reset pin level
	output logic                             reset_pin_oe,          // Reset pin drive enable
	output logic                             illegal_opcode,        // Stop taken as illegal
	output logic                             cpu_clock_run,         // Core clock allowed
	output logic                             lv_enable,             // Detector powered
	output logic                             lv_reset_enable,       // Detector may reset
	output logic                             lv_trip_select         // One selects 5 V
);

	typedef struct packed {
		logic [1:0]                  tv_sync;
		logic [wdg_pkg::PRE_W-1:0]   pre;
		logic [wdg_pkg::CNT_W-1:0]   cnt;
		logic [12:0]                 por_cnt;
		logic                        por_done;
		logic [7:0]                  opt;
		logic                        opt_written;
		logic                        wd_flag;
		wdg_pkg::wdg_mode_e          mode;
		logic [12:0]                 rec_cnt;
		logic [5:0]                  pulse_cnt;
		logic                        wd_reset;
		logic                        pin_o;
		logic                        pin_oe;
		logic                        illegal;
		logic                        cpu_run;
		logic                        lv_en;
		logic                        lv_rst_en;
		logic [31:0]                 rdata;
		logic                        ready;
		logic                        slverr;
	} wdg_state_s;

	localparam wdg_state_s ST_RESET = '{
		tv_sync:     2'b00,
		pre:         12'h000,
		cnt:         6'h00,
		por_cnt:     13'h0000,
		por_done:    1'b0,
		opt:         wdg_pkg::OPT_RESET_VALUE,
		opt_written: 1'b0,
		wd_flag:     1'b0,
		mode:        wdg_pkg::WDG_RUN,
		rec_cnt:     13'h0000,
		pulse_cnt:   6'h00,
		wd_reset:    1'b0,
		pin_o:       1'b1,
		pin_oe:      1'b0,
		illegal:     1'b0,
		cpu_run:     1'b1,
		lv_en:       1'b1,
		lv_rst_en:   1'b1,
		rdata:       32'h0000_0000,
		ready:       1'b0,
		slverr:      1'b0
	};

	wdg_state_s st_q;
	wdg_state_s st_d;

	function automatic logic addr_hit(input logic [wdg_pkg::ADDR_W-1:0] a);
		addr_hit = (a == wdg_pkg::ADDR_WATCHDOG_CLEAR) ||
			(a == wdg_pkg::ADDR_OPTION_CONTROL_ONE) ||
			(a == wdg_pkg::ADDR_WATCHDOG_STATUS);
	endfunction

	always_comb begin
		logic acc_first;
		logic wr_done;
		logic int_rst;
		logic disabled;
		logic rate_short;
		logic tick;
		logic expire;
		logic clear_req;
		logic stop_accept;
		logic [31:0] rd;
		acc_first   = 1'b0;
		wr_done     = 1'b0;
		int_rst     = 1'b0;
		disabled    = 1'b0;
		rate_short  = 1'b0;
		tick        = 1'b0;
		expire      = 1'b0;
		clear_req   = 1'b0;
		stop_accept = 1'b0;
		rd          = 32'h0000_0000;
		st_d        = st_q;

		st_d.tv_sync = {st_q.tv_sync[0], test_voltage_pin};

		// One wait state so read data can leave a flip-flop
		acc_first = psel && penable && !st_q.ready;
		wr_done   = psel && penable && st_q.ready && pwrite;
		st_d.ready = acc_first;
		if (acc_first) begin
			st_d.slverr = !addr_hit(paddr);
			case (paddr)
				wdg_pkg::ADDR_WATCHDOG_CLEAR: begin
					rd = {24'h000000, RESET_VECTOR_LOW};
				end
				wdg_pkg::ADDR_OPTION_CONTROL_ONE: begin
					rd = {24'h000000, st_q.opt};
				end
				wdg_pkg::ADDR_WATCHDOG_STATUS: begin
					rd[wdg_pkg::STS_WATCHDOG_FLAG] = st_q.wd_flag;
					rd[wdg_pkg::STS_IN_STOP]       = (st_q.mode != wdg_pkg::WDG_RUN);
					rd[wdg_pkg::STS_OPT_WRITTEN]   = st_q.opt_written;
					rd[wdg_pkg::STS_COUNT_LSB +: wdg_pkg::CNT_W] = st_q.cnt;
				end
				default: begin
					rd = 32'h0000_0000;
				end
			endcase
			st_d.rdata = rd;
		end else begin
			st_d.slverr = 1'b0;
		end

		clear_req = wr_done && (paddr == wdg_pkg::ADDR_WATCHDOG_CLEAR);

		// Write-once option register; reads always allowed
		if (wr_done && (paddr == wdg_pkg::ADDR_OPTION_CONTROL_ONE) && !st_q.opt_written) begin
			st_d.opt         = pwdata[7:0];
			st_d.opt_written = 1'b1;
		end

		// Set beats a software clear of the flag
		if (wr_done && (paddr == wdg_pkg::ADDR_WATCHDOG_STATUS) &&
			pwdata[wdg_pkg::STS_WATCHDOG_FLAG]) begin
			st_d.wd_flag = 1'b0;
		end

		disabled = st_q.opt[wdg_pkg::OPT_WATCHDOG_DISABLE] ||
			(monitor_mode && st_q.tv_sync[1]) ||
			(monitor_mode && break_active && break_watchdog_disable);
		rate_short = st_q.opt[wdg_pkg::OPT_WATCHDOG_RATE_SELECT];

		// Power-up delay holds the prescaler clear
		if (!st_q.por_done) begin
			st_d.por_cnt = st_q.por_cnt + 13'h0001;
			st_d.pre     = '0;
			if (st_q.por_cnt == wdg_pkg::POWER_UP_CYC - 13'h0001) begin
				st_d.por_done = 1'b1;
			end
		end else if (st_q.mode == wdg_pkg::WDG_RUN) begin
			// Counts on through wait mode; only stop halts it
			st_d.pre = st_q.pre + 12'h001;
			if (rate_short) begin
				tick   = (st_q.pre[6:0] == wdg_pkg::PRE_SHORT_WRAP);
				expire = (st_q.cnt == wdg_pkg::CNT_LAST) &&
					(st_q.pre[6:0] == wdg_pkg::PRE_SHORT_EXPIRE);
			end else begin
				tick   = (st_q.pre == wdg_pkg::PRE_LONG_WRAP);
				expire = (st_q.cnt == wdg_pkg::CNT_LAST) &&
					(st_q.pre == wdg_pkg::PRE_LONG_EXPIRE);
			end
			if (tick) begin
				st_d.cnt = st_q.cnt + 6'h01;
			end
		end
		if (disabled) begin
			expire   = 1'b0;
			st_d.cnt = '0;
		end

		if (clear_req) begin
			st_d.cnt       = '0;
			st_d.pre[11:4] = 8'h00;
		end

		// Stop handling; stop_wake or lv_reset_exit leaves stop through recovery
		st_d.illegal = 1'b0;
		case (st_q.mode)
			wdg_pkg::WDG_RUN: begin
				if (stop_exec && st_q.por_done) begin
					if (st_q.opt[wdg_pkg::OPT_STOP_ENABLE]) begin
						stop_accept = 1'b1;
					end else begin
						st_d.illegal = 1'b1;
					end
				end
				if (stop_accept) begin
					st_d.mode    = wdg_pkg::WDG_STOPPED;
					st_d.pre     = '0;
					st_d.cpu_run = 1'b0;
				end
			end
			wdg_pkg::WDG_STOPPED: begin
				st_d.pre = '0;
				if (stop_wake || lv_reset_exit) begin
					st_d.mode = wdg_pkg::WDG_RECOVER;
					if (st_q.opt[wdg_pkg::OPT_SHORT_STOP_RECOVERY] && !lv_reset_exit) begin
						st_d.rec_cnt = wdg_pkg::RECOVER_SHORT_CYC - 13'h0001;
					end else begin
						st_d.rec_cnt = wdg_pkg::RECOVER_LONG_CYC - 13'h0001;
					end
				end
			end
			wdg_pkg::WDG_RECOVER: begin
				st_d.pre = '0;
				if (st_q.rec_cnt == 13'h0000) begin
					st_d.mode    = wdg_pkg::WDG_RUN;
					st_d.cpu_run = 1'b1;
				end else begin
					st_d.rec_cnt = st_q.rec_cnt - 13'h0001;
				end
			end
			default: begin
				st_d.mode    = wdg_pkg::WDG_RUN;
				st_d.cpu_run = 1'b1;
			end
		endcase

		// Expiry drives the reset pin low for a fixed pulse
		if (st_q.pulse_cnt != 6'h00) begin
			st_d.pulse_cnt = st_q.pulse_cnt - 6'h01;
			if (st_q.pulse_cnt == 6'h01) begin
				st_d.wd_reset = 1'b0;
				st_d.pin_oe   = 1'b0;
			end
		end
		if (expire) begin
			st_d.pulse_cnt = wdg_pkg::RESET_PULSE_CYC;
			st_d.wd_reset  = 1'b1;
			st_d.pin_oe    = reset_pin_enable;
			st_d.wd_flag   = 1'b1;
		end
		st_d.pin_o = 1'b0;

		// Any internal reset restarts the counters and re-arms the options
		int_rst = expire || internal_reset_req;
		if (int_rst) begin
			st_d.pre         = '0;
			st_d.cnt         = '0;
			st_d.opt_written = 1'b0;
			st_d.mode        = wdg_pkg::WDG_RUN;
			st_d.cpu_run     = 1'b1;
			st_d.opt         = wdg_pkg::OPT_RESET_VALUE;
			st_d.opt[wdg_pkg::OPT_LV_TRIP_SELECT] =
				st_q.opt[wdg_pkg::OPT_LV_TRIP_SELECT];
			if (!expire) begin
				st_d.wd_flag = 1'b0;
			end
		end

		st_d.lv_en = !st_d.opt[wdg_pkg::OPT_LV_POWER_DISABLE] &&
			((st_d.mode == wdg_pkg::WDG_RUN) ||
			st_d.opt[wdg_pkg::OPT_LV_STOP_ENABLE]);
		st_d.lv_rst_en = !st_d.opt[wdg_pkg::OPT_LV_RESET_DISABLE] && st_d.lv_en;
	end

	// Power-on reset loads ST_RESET and clears all option bits, trip select included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata          = st_q.rdata;
	assign pready          = st_q.ready;
	assign pslverr         = st_q.slverr;
	assign watchdog_reset  = st_q.wd_reset;
	assign reset_pin_o     = st_q.pin_o;
	assign reset_pin_oe    = st_q.pin_oe;
	assign illegal_opcode  = st_q.illegal;
	assign cpu_clock_run   = st_q.cpu_run;
	assign lv_enable       = st_q.lv_en;
	assign lv_reset_enable = st_q.lv_rst_en;
	assign lv_trip_select  = st_q.opt[wdg_pkg::OPT_LV_TRIP_SELECT];

endmodule

// File: test/wdg_sva.sv
// Port-level assertion checker for the watchdog block
`timescale 1ns/1ps
module wdg_sva #(
	parameter logic [7:0] RESET_VECTOR_LOW = 8'h00
) (
	input wire logic                       pclk,             // Clock
	input wire logic                       presetn,          // Reset, low
	input wire logic                       psel,             // APB select
	input wire logic                       penable,          // APB enable
	input wire logic                       pwrite,           // APB direction
	input wire logic [wdg_pkg::ADDR_W-1:0] paddr,            // APB address
	input wire logic [31:0]                prdata,           // APB read data
	input wire logic                       pready,           // APB ready
	input wire logic                       pslverr,          // APB error
	input wire logic                       stop_exec,        // Stop pulse
	input wire logic                       reset_pin_enable, // Pin function on
	input wire logic                       watchdog_reset,   // Expiry reset
	input wire logic                       reset_pin_o,      // Pin level
	input wire logic                       reset_pin_oe,     // Pin drive
	input wire logic                       illegal_opcode,   // Illegal stop
	input wire logic                       cpu_clock_run     // Core clock
);
	logic [6:0] hi_q;
	logic       mapped;
	assign mapped = paddr inside {wdg_pkg::ADDR_WATCHDOG_CLEAR,
		wdg_pkg::ADDR_OPTION_CONTROL_ONE, wdg_pkg::ADDR_WATCHDOG_STATUS};
	// Counts high cycles of the reset pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hi_q <= 7'h00;
		else
			hi_q <= watchdog_reset ? hi_q + 7'h01 : 7'h00;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pulse_len: assert property ($fell(watchdog_reset) |-> hi_q == 7'h20)
		else $error("reset pulse length wrong");
	a_pin_drive: assert property (reset_pin_oe |-> !reset_pin_o && watchdog_reset)
		else $error("reset pin driven outside pulse");
	a_pin_enable: assert property ($rose(watchdog_reset) && $past(reset_pin_enable) |-> reset_pin_oe)
		else $error("reset pin not driven");
	a_ready_wait: assert property (psel && $rose(penable) |=> pready)
		else $error("ready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than a cycle");
	a_error_map: assert property (pready |-> pslverr == !mapped)
		else $error("error flag wrong");
	a_clear_read: assert property (pready && !pwrite && paddr == wdg_pkg::ADDR_WATCHDOG_CLEAR
		|-> prdata[7:0] == RESET_VECTOR_LOW)
		else $error("clear location read wrong");
	a_illegal_pulse: assert property (illegal_opcode |-> $past(stop_exec) ##1 !illegal_opcode)
		else $error("illegal pulse wrong");
	a_stop_cause: assert property ($fell(cpu_clock_run) |-> $past(stop_exec) && !illegal_opcode)
		else $error("clock stopped without stop");
endmodule

bind wdg_top wdg_sva #(.RESET_VECTOR_LOW(RESET_VECTOR_LOW)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.stop_exec(stop_exec), .reset_pin_enable(reset_pin_enable),
	.watchdog_reset(watchdog_reset), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
	.illegal_opcode(illegal_opcode), .cpu_clock_run(cpu_clock_run)
);

// File: test/tb.sv
// Self-checking testbench for the watchdog block
`timescale 1ns/1ps
module tb;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, watchdog_reset, reset_pin_o, reset_pin_oe;
	logic        illegal_opcode, cpu_clock_run, lv_enable, lv_reset_enable, lv_trip_select;
	logic        internal_reset_req = 1'b0, stop_exec = 1'b0, stop_wake = 1'b0;
	logic        lv_reset_exit = 1'b0, reset_pin_enable = 1'b1, wr_prev = 1'b0;
	logic        monitor_mode = 1'b0, test_voltage_pin = 1'b0;
	logic        break_active = 1'b0, break_watchdog_disable = 1'b0;
	logic [32:0] exp_q[$], msk_q[$];
	int          fails = 0, checks_done = 0, n, i, rises = 0, ills = 0;
	integer      seed = 32'hB106D7E2;
	localparam logic [32:0] ERR = 33'h100000000;
	localparam logic [32:0] BYTE = 33'h1000000FF;

	wdg_top uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.internal_reset_req(internal_reset_req), .stop_exec(stop_exec), .stop_wake(stop_wake),
		.lv_reset_exit(lv_reset_exit), .monitor_mode(monitor_mode),
		.test_voltage_pin(test_voltage_pin), .break_active(break_active),
		.break_watchdog_disable(break_watchdog_disable), .reset_pin_enable(reset_pin_enable),
		.watchdog_reset(watchdog_reset), .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe),
		.illegal_opcode(illegal_opcode), .cpu_clock_run(cpu_clock_run), .lv_enable(lv_enable),
		.lv_reset_enable(lv_reset_enable), .lv_trip_select(lv_trip_select)
	);

	always #2.5 pclk = ~pclk;

	task chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task give_verdict;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Expectation noted before the request; the monitor compares it
	task apb(input logic wr, input logic [17:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No fixed wait count; a stuck slave is left to the bench watchdog
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	always @(posedge pclk) begin
		wr_prev <= watchdog_reset;
		if (watchdog_reset === 1'b1 && wr_prev === 1'b0)
			rises++;
		if (illegal_opcode === 1'b1)
			ills++;
		if (psel && penable && pready === 1'b1)
			chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
	end

	initial begin
		repeat (80000) @(posedge pclk);
		fails++;
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h0, 33'h0, BYTE);
		apb(1'b0, wdg_pkg::ADDR_WATCHDOG_CLEAR, 32'h0, 33'h0, BYTE);
		apb(1'b0, 18'h00100, 32'h0, ERR, ERR);
		apb(1'b1, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h86, 33'h0, ERR);
		apb(1'b1, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h01, 33'h0, ERR);
		apb(1'b0, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h0, 33'h86, BYTE);
		repeat (4200) @(posedge pclk);
		// Second stop exits by low voltage, which must force the long recovery
		for (i = 0; i < 2; i++) begin
			stop_exec <= 1'b1;
			@(posedge pclk);
			stop_exec <= 1'b0;
			repeat (3) @(posedge pclk);
			chk({32'h0, cpu_clock_run}, 33'h0);
			stop_wake <= 1'b1;
			lv_reset_exit <= (i == 1);
			@(posedge pclk);
			stop_wake <= 1'b0;
			lv_reset_exit <= 1'b0;
			for (n = 0; n < 5000 && cpu_clock_run !== 1'b1; n++)
				@(posedge pclk);
			chk({32'h0, n >= (i ? 4096 : 32) && n <= (i ? 4104 : 40)}, 33'h1);
		end
		apb(1'b1, wdg_pkg::ADDR_WATCHDOG_CLEAR, $random(seed), 33'h0, ERR);
		for (n = 0; n < 9000 && watchdog_reset !== 1'b1; n++)
			@(posedge pclk);
		chk({32'h0, n >= 8160 && n <= 8200}, 33'h1);
		chk({32'h0, reset_pin_oe}, 33'h1);
		repeat (40) @(posedge pclk);
		apb(1'b0, wdg_pkg::ADDR_WATCHDOG_STATUS, 32'h0, 33'h1, 33'h100003F01);
		apb(1'b0, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h0, 33'h0, BYTE);
		stop_exec <= 1'b1;
		@(posedge pclk);
		stop_exec <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({1'b0, ills}, 33'h1);
		apb(1'b1, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'hB9, 33'h0, ERR);
		repeat (2) @(posedge pclk);
		chk({30'h0, lv_enable, lv_reset_enable, lv_trip_select}, 33'h1);
		repeat (9000) @(posedge pclk);
		chk({1'b0, rises}, 33'h1);
		internal_reset_req <= 1'b1;
		@(posedge pclk);
		internal_reset_req <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({30'h0, lv_enable, lv_reset_enable, lv_trip_select}, 33'h7);
		// Test voltage, then break, must each hold off a short-period expiry
		monitor_mode <= 1'b1;
		test_voltage_pin <= 1'b1;
		apb(1'b1, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h88, 33'h0, ERR);
		repeat (9000) @(posedge pclk);
		chk({1'b0, rises}, 33'h1);
		test_voltage_pin <= 1'b0;
		break_active <= 1'b1;
		break_watchdog_disable <= 1'b1;
		repeat (9000) @(posedge pclk);
		chk({1'b0, rises}, 33'h1);
		monitor_mode <= 1'b0;
		break_active <= 1'b0;
		break_watchdog_disable <= 1'b0;
		reset_pin_enable <= 1'b0;
		for (n = 0; n < 9000 && watchdog_reset !== 1'b1; n++)
			@(posedge pclk);
		chk({32'h0, n >= 8000 && n <= 8200}, 33'h1);
		chk({32'h0, reset_pin_oe}, 33'h0);
		repeat (40) @(posedge pclk);
		chk({31'h0, rises == 2, lv_trip_select}, 33'h3);
		// Power-on reset mid-run clears trip select and restarts the delay
		presetn <= 1'b0;
		reset_pin_enable <= 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, wdg_pkg::ADDR_OPTION_CONTROL_ONE, 32'h02, 33'h0, ERR);
		stop_exec <= 1'b1;
		@(posedge pclk);
		stop_exec <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, cpu_clock_run, lv_trip_select}, 33'h2);
		give_verdict();
	end
endmodule
